// ===== src/ulpi_protocol.sv
// Purpose: Transceiver side of the link bus: commands, registers, status
// Assumes: Link keeps its side of the handshakes
// Notes: Register array is local; status bytes pass a two-entry buffer
`include "ulpi_access_regs.svh"

// Behaviour
// - Command 01b is transmit; low 6 bits go out as tx_pid with tx_start, zero included
// - Command 10b is immediate write with 6-bit address
// - Write with address 101111b takes full address from next byte
// - Command 11b is immediate read with 6-bit address
// - Read with address 2Fh takes full address from a later byte
// - Register contents held in low power mode
// - Raise throttle ack for command and any address byte, drop ack, take data byte next edge, store
// - Owner flag stays low during write; commit on the edge where halt strobe is high
// - Read: ack takes command, then owner flag rises and ack drops together
// - After turnaround drive register value one cycle, then release bus
// - Extended read reads address byte, takes bus, returns data
// - Status byte sent only while device owns bus in synchronous mode
// - Line level change with owner flag low sends status at once
// - During receive send status whenever owning bus and ack low
// - During transmit withhold status until halt strobe seen
// - VBUS or ID comparator change sends a status byte
// - Status after start-up release if halt strobe is low then, and after leaving low power on halt
// - One turnaround cycle on each owner change; bus ignored then
// - Single data rate on rising edges of the interface clock
module ulpi_protocol
   import ulpi_access_pkg::*;
#(
   parameter int START_DELAY_NS = `START_DELAY_NS
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic bus_oe,
   output logic bus_owner,
   output logic throttle_ack,
   input wire logic halt_strobe,
   input wire logic [1:0] line_level,
   input wire logic [1:0] vbus_state,
   input wire logic id_state,
   input wire logic [1:0] rx_event,
   input wire logic rx_active,
   input wire logic suspend_mode,
   output logic [5:0] tx_pid,
   output logic tx_start
);
   import ulpi_access_pkg::*;

   localparam int START_CYC_RAW = (START_DELAY_NS + `CLK_PERIOD_NS - 1)
      / `CLK_PERIOD_NS;
   localparam int START_CYC = (START_CYC_RAW < 1) ? 1 : START_CYC_RAW;

   // ==========================================================
   // Input synchronisers (pins outside the clock domain)
   logic [1:0] ll_s1, ll_s2, vb_s1, vb_s2, ev_s1, ev_s2;
   logic id_s1, id_s2, ra_s1, ra_s2, sm_s1, sm_s2;
   logic [1:0] ll_last_r, vb_last_r;
   logic id_last_r, sm_last_r;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         {ll_s1, ll_s2, vb_s1, vb_s2, ev_s1, ev_s2} <= '0;
         {id_s1, id_s2, ra_s1, ra_s2, sm_s1, sm_s2} <= '0;
         ll_last_r <= 2'h0;
         vb_last_r <= 2'h0;
         id_last_r <= 1'b0;
         sm_last_r <= 1'b0;
      end
      else
      begin
         ll_s1 <= line_level;
         ll_s2 <= ll_s1;
         vb_s1 <= vbus_state;
         vb_s2 <= vb_s1;
         ev_s1 <= rx_event;
         ev_s2 <= ev_s1;
         id_s1 <= id_state;
         id_s2 <= id_s1;
         ra_s1 <= rx_active;
         ra_s2 <= ra_s1;
         sm_s1 <= suspend_mode;
         sm_s2 <= sm_s1;
         ll_last_r <= ll_s2;
         vb_last_r <= vb_s2;
         id_last_r <= id_s2;
         sm_last_r <= sm_s2;
      end
   end

   // ==========================================================
   // Status byte buffer
   logic [7:0] stat_byte;
   logic stat_push, stat_in_rdy, stat_out_vld, stat_pop;
   logic [7:0] stat_out;

   always_comb
   begin
      stat_byte = '0;
      stat_byte[`STATUS_LS_LO +: 2] = ll_s2;
      stat_byte[`STATUS_VB_LO +: 2] = vb_s2;
      stat_byte[`STATUS_EV_LO +: 2] = ev_s2;
      stat_byte[`STATUS_ID_BIT] = id_s2;
   end

   skid_buffer #(.WIDTH(8)) u_stat_buf (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_data(stat_byte),
      .in_valid(stat_push),
      .in_ready(stat_in_rdy),
      .out_data(stat_out),
      .out_valid(stat_out_vld),
      .out_ready(stat_pop)
   );

   // ==========================================================
   // Bus controller
   bus_state_e st_r, st_nxt;
   logic [7:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
   logic [7:0] regs_r [256];
   logic wr_en;
   logic [7:0] bus_out_nxt;
   logic bus_oe_nxt, owner_nxt, ack_nxt;
   logic [7:0] out_r;
   logic oe_r, owner_r, ack_r;
   logic [15:0] start_cnt_r, start_cnt_nxt;
   logic pend_r, pend_nxt;
   logic [5:0] pid_nxt, pid_r;
   logic txs_nxt, txs_r;
   logic wake_r, wake_nxt;

   always_comb
   begin
      st_nxt = st_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      wr_en = 1'b0;
      bus_out_nxt = out_r;
      bus_oe_nxt = 1'b0;
      owner_nxt = owner_r;
      ack_nxt = 1'b0;
      start_cnt_nxt = start_cnt_r;
      pend_nxt = pend_r;
      stat_pop = 1'b0;
      pid_nxt = pid_r;
      txs_nxt = 1'b0;
      wake_nxt = wake_r;
      stat_push = 1'b0;
      // Status events: line change, comparator change, receive, wake
      if ((ll_s2 != ll_last_r) && !owner_r)
         pend_nxt = 1'b1;
      if ((vb_s2 != vb_last_r) || (id_s2 != id_last_r))
         pend_nxt = 1'b1;
      if (sm_last_r && !sm_s2)
         wake_nxt = 1'b1;
      if (ra_s2)
         pend_nxt = 1'b1;
      if (pend_r && stat_in_rdy && !sm_s2 && st_r != ST_TX)
      begin
         stat_push = 1'b1;
         pend_nxt = 1'b0;
      end
      unique case (st_r)
         ST_START:
         begin
            owner_nxt = 1'b1;
            if (start_cnt_r == 16'(START_CYC))
            begin
               if (!halt_strobe)
                  pend_nxt = 1'b1;
               owner_nxt = 1'b0;
               st_nxt = ST_TURN_BACK;
            end
            else
               start_cnt_nxt = start_cnt_r + 16'h1;
         end
         ST_IDLE:
         begin
            if (sm_s2)
               st_nxt = ST_IDLE;
            else if (wake_r && halt_strobe)
            begin
               wake_nxt = 1'b0;
               pend_nxt = 1'b1;
            end
            else if (bus_in[`CMD_KIND_HI:`CMD_KIND_LO] != `CMD_KIND_IDLE)
            begin
               ack_nxt = 1'b1;
               unique case (bus_in[`CMD_KIND_HI:`CMD_KIND_LO])
                  `CMD_KIND_WR:
                  begin
                     addr_nxt = {2'h0, bus_in[5:0]};
                     if (bus_in[5:0] == `CMD_EXT_ADDR)
                        addr_nxt = bus_in;
                     st_nxt = ST_WR_ACK;
                  end
                  `CMD_KIND_RD:
                  begin
                     addr_nxt = {2'h0, bus_in[5:0]};
                     st_nxt = ST_RD_ACK;
                     if (bus_in[5:0] == `CMD_EXT_ADDR)
                     begin
                        addr_nxt = bus_in;
                        st_nxt = ST_WR_ACK;
                     end
                  end
                  default:
                  begin
                     pid_nxt = bus_in[5:0];
                     txs_nxt = 1'b1;
                     st_nxt = ST_TX;
                  end
               endcase
            end
            else if (stat_out_vld)
            begin
               owner_nxt = 1'b1;
               st_nxt = ST_STAT_TURN;
            end
         end
         ST_WR_ACK:
         begin
            st_nxt = ST_WR_DATA;
            if (addr_r == {`CMD_KIND_RD, `CMD_EXT_ADDR})
            begin
               ack_nxt = 1'b1;
               st_nxt = ST_RD_EXT;
            end
            else if (addr_r == {`CMD_KIND_WR, `CMD_EXT_ADDR})
            begin
               ack_nxt = 1'b1;
               st_nxt = ST_WR_EXT;
            end
         end
         ST_WR_EXT:
         begin
            addr_nxt = bus_in;
            st_nxt = ST_WR_DATA;
         end
         ST_WR_DATA:
         begin
            wdata_nxt = bus_in;
            st_nxt = ST_WR_END;
         end
         ST_WR_END:
         begin
            if (halt_strobe)
            begin
               wr_en = 1'b1;
               st_nxt = ST_IDLE;
            end
         end
         ST_RD_EXT:
         begin
            addr_nxt = bus_in;
            owner_nxt = 1'b1;
            st_nxt = ST_RD_TURN;
         end
         ST_RD_ACK:
         begin
            owner_nxt = 1'b1;
            st_nxt = ST_RD_TURN;
         end
         ST_RD_TURN:
         begin
            bus_oe_nxt = 1'b1;
            bus_out_nxt = regs_r[addr_r];
            st_nxt = ST_RD_DATA;
         end
         ST_RD_DATA:
         begin
            owner_nxt = 1'b0;
            st_nxt = ST_TURN_BACK;
         end
         ST_TURN_BACK:
            st_nxt = ST_IDLE;
         ST_STAT_TURN:
         begin
            bus_oe_nxt = 1'b1;
            bus_out_nxt = stat_out;
            stat_pop = 1'b1;
            st_nxt = ST_STAT_SEND;
         end
         ST_STAT_SEND:
         begin
            if (stat_out_vld && ra_s2)
            begin
               bus_oe_nxt = 1'b1;
               bus_out_nxt = stat_out;
               stat_pop = 1'b1;
            end
            else
            begin
               owner_nxt = 1'b0;
               st_nxt = ST_TURN_BACK;
            end
         end
         ST_TX:
         begin
            ack_nxt = !halt_strobe;
            if (halt_strobe)
               st_nxt = ST_IDLE;
         end
         default:
            st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= ST_START;
         addr_r <= 8'h00;
         wdata_r <= 8'h00;
         out_r <= `IDLE_BYTE;
         oe_r <= 1'b0;
         owner_r <= 1'b1;
         ack_r <= 1'b0;
         start_cnt_r <= 16'h0;
         pend_r <= 1'b0;
         pid_r <= 6'h00;
         txs_r <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         out_r <= bus_out_nxt;
         oe_r <= bus_oe_nxt;
         owner_r <= owner_nxt;
         ack_r <= ack_nxt;
         start_cnt_r <= start_cnt_nxt;
         pend_r <= pend_nxt;
         pid_r <= pid_nxt;
         txs_r <= txs_nxt;
         wake_r <= wake_nxt;
      end
   end

   // Register array, not reset, untouched outside writes
   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
         regs_r[addr_r] <= wdata_r;
   end

   assign bus_out = out_r;
   assign bus_oe = oe_r;
   assign bus_owner = owner_r;
   assign throttle_ack = ack_r;
   assign tx_pid = pid_r;
   assign tx_start = txs_r;

   // ==========================================================
   // Checks
   sequence s_wr_cmd;
      st_r == ST_IDLE && !sm_s2 && !(wake_r && halt_strobe)
         && bus_in[7:6] == `CMD_KIND_WR;
   endsequence

   a_write_owner_low: assert property (@(posedge ref_clk) disable iff (rst)
      s_wr_cmd |=> !owner_r[*3])
      else $error("owner flag rose during write");
   a_write_ack: assert property (@(posedge ref_clk) disable iff (rst)
      s_wr_cmd |=> throttle_ack)
      else $error("no ack after write command");
   a_read_owner: assert property (@(posedge ref_clk) disable iff (rst)
      st_r == ST_RD_ACK |=> owner_r && !ack_r)
      else $error("read did not take bus");
   a_read_data: assert property (@(posedge ref_clk) disable iff (rst)
      st_r == ST_RD_TURN |=> oe_r ##1 !owner_r)
      else $error("read data phase wrong");
   a_turn_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(owner_r) |-> !oe_r)
      else $error("drove bus in turnaround");
   a_drive_owned: assert property (@(posedge ref_clk) disable iff (rst)
      oe_r |-> owner_r)
      else $error("drove bus without owning it");
   a_commit_halt: assert property (@(posedge ref_clk) disable iff (rst)
      wr_en |-> halt_strobe && st_r == ST_WR_END)
      else $error("commit without halt strobe");
   a_ext_addr: assert property (@(posedge ref_clk) disable iff (rst)
      st_r == ST_RD_EXT |=> addr_r == $past(bus_in))
      else $error("extended address not taken");
endmodule : ulpi_protocol

// ===== shared/ulpi_access_regs.svh
// Purpose: Constants for the transceiver-side link protocol logic
// Assumes: Single clock, rising edge transfers
// Notes: Command codes, field offsets and timing values only, no logic
`ifndef ULPI_ACCESS_REGS_SVH
`define ULPI_ACCESS_REGS_SVH
`define CMD_KIND_HI 7
`define CMD_KIND_LO 6
`define CMD_KIND_IDLE 2'h0
`define CMD_KIND_TX 2'h1
`define CMD_KIND_WR 2'h2
`define CMD_KIND_RD 2'h3
`define CMD_EXT_ADDR 6'h2f
`define IDLE_BYTE 8'h00
`define ADDR_WIDTH 8
`define STATUS_LS_LO 0
`define STATUS_VB_LO 2
`define STATUS_EV_LO 4
`define STATUS_ID_BIT 6
`define START_DELAY_NS 100
`define CLK_PERIOD_NS 10
`endif

// ===== shared/ulpi_access_pkg.sv
// Purpose: Types shared by the protocol logic
// Assumes: Nothing beyond the constants header
// Notes: States of the bus controller
package ulpi_access_pkg;
   typedef enum logic [3:0] {
      ST_START, ST_IDLE, ST_WR_ACK, ST_WR_EXT, ST_WR_DATA, ST_WR_END,
      ST_RD_ACK, ST_RD_EXT, ST_RD_TURN, ST_RD_DATA, ST_TURN_BACK,
      ST_STAT_TURN, ST_STAT_SEND, ST_TX
   } bus_state_e;
   typedef logic [7:0] byte_t;
endpackage : ulpi_access_pkg

// ===== src/skid_buffer.sv
// Purpose: Two-entry buffer between producer and consumer
// Assumes: Same clock on both sides
// Notes: Width is a parameter, depth fixed at two
module skid_buffer #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [WIDTH-1:0] mem_r [2];
   logic [WIDTH-1:0] mem_nxt [2];
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   // ==========================================================
   // Next state
   always_comb
   begin
      push = in_valid && (cnt_r != 2'h2);
      pop = out_ready && (cnt_r != 2'h0);
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (push)
      begin
         mem_nxt[wp_r] = in_data;
         wp_nxt = !wp_r;
      end
      if (pop)
         rp_nxt = !rp_r;
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         mem_r <= mem_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rp_r];

   a_no_overflow: assert property (@(posedge ref_clk) disable iff (rst)
      cnt_r != 2'h3) else $error("buffer count out of range");
endmodule : skid_buffer

// ===== tb/link_model.sv
// Purpose: Link controller model driving the shared bus
// Assumes: Device outputs change just after rising edges
// Notes: Leaves the bus undriven around every owner change
module link_model
(
   input wire logic ref_clk,
   input wire logic bus_owner,
   input wire logic bus_oe,
   input wire ulpi_access_pkg::byte_t bus_out,
   input wire logic throttle_ack,
   output ulpi_access_pkg::byte_t link_data,
   output logic link_oe,
   output logic halt_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   import ulpi_access_pkg::*;
   byte_t stat_q [$];
   logic own_q1 = 1'b1;
   logic own_q2 = 1'b1;
   bit in_read = 1'b0;
   // ==========================================================
   // Bus release and status capture
   assign link_oe = !bus_owner && !own_q1;
   always @(posedge ref_clk)
   begin
      own_q1 <= bus_owner;
      own_q2 <= own_q1;
      if (bus_oe && !in_read)
      begin
         stat_q.push_back(bus_out);
      end
   end
   initial
   begin
      link_data = 8'h00;
      halt_strobe = 1'b0;
   end
   // ==========================================================
   // Transfers
   task step();
      @(posedge ref_clk);
      #1;
   endtask : step
   task halt();
      halt_strobe = 1'b1;
      step();
      halt_strobe = 1'b0;
   endtask : halt
   // Kind 0 write, 1 read, 2 transmit
   task automatic xfer(input byte_t cmd, input byte_t addr,
      input byte_t data, input int kind, output byte_t q, output bit ok);
      int n;
      bit done;
      q = 8'hxx;
      done = 1'b0;
      n = 0;
      while (!done)
      begin
         while (!(link_oe && !own_q2))
            step();
         link_data = cmd;
         step();
         n = 0;
         while (!throttle_ack && !bus_owner && n < 20)
         begin
            step();
            n++;
         end
         done = throttle_ack && !bus_owner;
         step();
         if (!done)
            link_data = 8'h00;
      end
      ok = (n == 0);
      if (cmd[5:0] == 6'h2f && kind != 2)
      begin
         link_data = addr;
         step();
      end
      if (kind == 1)
      begin
         link_data = 8'h00;
         ok &= bus_owner && !throttle_ack && !bus_oe;
         in_read = 1'b1;
         step();
         ok &= bus_oe;
         q = bus_out;
         step();
         ok &= !bus_owner;
         in_read = 1'b0;
      end
      else
      begin
         if (kind == 0)
         begin
            link_data = data;
            ok &= !throttle_ack && !bus_owner;
            step();
         end
         link_data = 8'h00;
         halt();
         ok &= !bus_owner && (kind == 2 || !throttle_ack);
      end
   endtask : xfer
endmodule : link_model

// ===== tb/tb.sv
// Purpose: Self-checking bench for the transceiver protocol logic
// Assumes: Link model keeps its side of every handshake
// Notes: Random registers and status events, transmit ids 0 to 15 in order
`define CHK(nm, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
      end \
   end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ulpi_access_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic bus_oe, bus_owner, throttle_ack, halt_strobe, link_oe, tx_start;
   logic [1:0] line_level = 2'h0;
   logic [1:0] vbus_state = 2'h0;
   logic [1:0] rx_event = 2'h0;
   logic id_state = 1'b0;
   logic suspend_mode = 1'b0;
   logic rx_active = 1'b0;
   logic [5:0] tx_pid;
   byte_t bus_in, bus_out, link_data, q, a, pid_seen;
   byte_t last = 8'h00;
   byte_t mem [256];
   bit ok;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int tx_count = 0;
   int seed = 32'h0cb7;
   // ==========================================================
   // Clock, bus wire and watchdog
   always #5 ref_clk = ~ref_clk;
   assign bus_in = bus_oe ? bus_out : (link_oe ? link_data : ~last);
   always @(posedge ref_clk)
   begin
      last <= bus_in;
      cycles <= cycles + 1;
      if (tx_start)
      begin
         tx_count++;
         pid_seen <= {2'h0, tx_pid};
      end
      if (cycles == 20000)
      begin
         err_total++;
         complete_run();
      end
   end
   ulpi_protocol #(.START_DELAY_NS(20)) ulpi_protocol_inst (
      .ref_clk(ref_clk), .rst(rst), .bus_in(bus_in), .bus_out(bus_out),
      .bus_oe(bus_oe), .bus_owner(bus_owner), .throttle_ack(throttle_ack),
      .halt_strobe(halt_strobe), .line_level(line_level),
      .vbus_state(vbus_state), .id_state(id_state), .rx_event(rx_event),
      .rx_active(rx_active), .suspend_mode(suspend_mode), .tx_pid(tx_pid),
      .tx_start(tx_start));
   link_model link_model_inst (
      .ref_clk(ref_clk), .bus_owner(bus_owner), .bus_oe(bus_oe),
      .bus_out(bus_out), .throttle_ack(throttle_ack),
      .link_data(link_data), .link_oe(link_oe), .halt_strobe(halt_strobe));
   // ==========================================================
   // Helpers
   function automatic byte_t status_exp();
      return {1'b0, id_state, rx_event, vbus_state, line_level};
   endfunction : status_exp
   task automatic acc(input bit rd, input byte_t ad, input byte_t d);
      byte_t c;
      c = {1'b1, rd, (ad < 8'h40 && ad != 8'h2f) ? ad[5:0] : 6'h2f};
      link_model_inst.xfer(c, ad, d, int'(rd), q, ok);
      `CHK("handshake", 1'b1, ok)
      if (rd)
         `CHK("read data", mem[ad], q)
      else
         mem[ad] = d;
   endtask : acc
   task automatic expect_status();
      int n;
      n = 0;
      while (link_model_inst.stat_q.size() == 0 && n < 40)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      q = link_model_inst.stat_q.size() != 0 ?
         link_model_inst.stat_q.pop_front() : 8'hxx;
      `CHK("status", status_exp(), q)
   endtask : expect_status
   task test_end(input string nm);
      $display("Test %s finished, %0d mismatches so far", nm, err_total);
   endtask : test_end
   task complete_run();
      $display("Counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   // ==========================================================
   // Main sequence
   initial
   begin
      byte_t corner [6] = '{8'h00, 8'h2f, 8'h3f, 8'h40, 8'hae, 8'hff};
      repeat (20) @(posedge ref_clk);
      #1 rst = 1'b0;
      while (bus_owner !== 1'b0)
         @(posedge ref_clk);
      expect_status();
      test_end("startup");
      foreach (corner[i])
         acc(1'b0, corner[i], 8'h5a ^ corner[i]);
      foreach (corner[i])
         acc(1'b1, corner[i], 8'h00);
      repeat (12)
      begin
         a = byte_t'($random(seed));
         acc(1'b0, a, byte_t'($random(seed)));
         acc(1'b1, a, 8'h00);
      end
      test_end("registers");
      for (int p = 0; p < 16; p++)
      begin
         link_model_inst.xfer({4'h4, 4'(p)}, 8'h00, 8'h00, 2, q, ok);
         `CHK("tx end", 1'b1, ok)
         `CHK("tx start", p + 1, tx_count)
         `CHK("tx id", byte_t'(p), pid_seen)
      end
      test_end("transmit");
      link_model_inst.stat_q.delete();
      for (int i = 0; i < 9; i++)
      begin
         repeat (6) @(posedge ref_clk);
         #1;
         case (i % 3)
            0: line_level = line_level ^ (2'($random(seed)) | 2'h1);
            1: vbus_state = vbus_state + 2'h1;
            default: id_state = ~id_state;
         endcase
         rx_event = (i % 3 == 0) ? 2'($random(seed)) : rx_event;
         expect_status();
      end
      test_end("status");
      rx_active = 1'b1;
      repeat (3)
         expect_status();
      rx_active = 1'b0;
      repeat (20) @(posedge ref_clk);
      #1 link_model_inst.stat_q.delete();
      test_end("receive");
      acc(1'b0, 8'h9c, 8'h3c);
      suspend_mode = 1'b1;
      repeat (10) @(posedge ref_clk);
      #1 suspend_mode = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 link_model_inst.stat_q.delete();
      link_model_inst.halt();
      expect_status();
      acc(1'b1, 8'h9c, 8'h00);
      test_end("suspend");
      complete_run();
   end
endmodule : tb
